// >>> pkg/pms_pkg.sv
// Constants, types and mode encodings for the converter power-mode sequencer.
// Assumes a single 200 MHz clock; all pin inputs are synchronous to it.
// Overview of operation
// R1: Normal mode keeps the converter fully powered; no power-up delay applies.
// R2: Reset loads the power-mode field with the normal setting.
// R3: Autoshutdown powers everything down when each conversion finishes.
// R4: Control register contents are kept unchanged through any shutdown.
// R5: Entering autoshutdown puts the track-and-hold in hold for the whole shutdown.
// R6: Autoshutdown wakes on convert-start rising edge: power up, back to track.
// R7: Host should idle convert-start low between conversions for longest shutdown.
// R8: Host waits at least 10 ms after autoshutdown wake before converting; the bench host waits WAIT_CAP, 2000 cycles (10 us).
// R9: Autostandby powers down all but reference and buffer after each conversion.
// R10: Standby holds in hold until convert-start rises, which powers up and tracks.
// R11: Host waits 600 ns (external) or 7 us (internal reference) after standby.
// R12: Writing full shutdown powers all down and holds on the write strobe rise.
// R13: Full shutdown persists until a write changes the power-mode bits.
// R14: Writing normal mode during full shutdown powers up and tracks on that edge.
// R15: Host allows 10 ms after full shutdown before the next convert-start fall; the bench host allows WAIT_CAP, 2000 cycles (10 us).
// R16: Host services a busy-driven DMA request before the next conversion ends.
// R17: Convert-start falling edge starts a conversion and puts track-and-hold in hold.
// R18: Busy is high from convert-start fall until conversion ends, then low.
// R19: Control data is captured on write-strobe rise; mode changes act from there.
// R20: Convert-start edges are ignored while in full shutdown.
package pms_pkg;
	localparam int PMS_CTRL_W = 12;
	localparam int PMS_PM_LOW_POS = 0;
	localparam int PMS_PM_HIGH_POS = 1;
	localparam logic [11:0] PMS_CTRL_RESET = 12'h000;
	localparam logic [1:0] PMS_PM_NORMAL = 2'h0;
	localparam logic [1:0] PMS_PM_AUTO_SHDN = 2'h1;
	localparam logic [1:0] PMS_PM_AUTO_STBY = 2'h2;
	localparam logic [1:0] PMS_PM_FULL_SHDN = 2'h3;
	localparam int PMS_CLK_MHZ = 200;
	localparam int PMS_CONV_NS = 525;
	localparam int PMS_CONV_CYCLES = (PMS_CONV_NS * PMS_CLK_MHZ) / 1000;
	localparam int PMS_CNT_W = 10;
	typedef enum logic [1:0] {
		PMS_PWR_ON,
		PMS_PWR_STANDBY,
		PMS_PWR_SHUTDOWN
	} pms_pwr_e;
endpackage : pms_pkg

// >>> pkg/pms_evt_if.sv
// Edge events of the convert-start and write-strobe pins, passed to the sequencer.
// Assumes the detector and sequencer share one clock.
interface pms_evt_if;
	logic cs_fall;
	logic cs_rise;
	logic wr_rise;
	modport det (output cs_fall, output cs_rise, output wr_rise);
	modport seq (input cs_fall, input cs_rise, input wr_rise);
endinterface : pms_evt_if

// >>> hw/pms_edge_det.sv
// Edge detector for the active-low convert-start and write strobe pins.
// Assumes pins are synchronous to clk_in; idle level of both is high.
module pms_edge_det
	import pms_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic convert_start_n_in,
	input wire logic wr_n_in,
	pms_evt_if.det evt
);
	logic cs_reg, cs_next, wr_reg, wr_next;

	always_comb
	begin
		cs_next = convert_start_n_in;
		wr_next = wr_n_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			// Reload from the pins, so a convert-start idling low through reset
			// gives no false fall, and so no false conversion, on release
			cs_reg <= cs_next;
			wr_reg <= wr_next;
		end
		else
		begin
			cs_reg <= cs_next;
			wr_reg <= wr_next;
		end
	end

	assign evt.cs_fall = cs_reg & ~convert_start_n_in;
	assign evt.cs_rise = ~cs_reg & convert_start_n_in;
	assign evt.wr_rise = ~wr_reg & wr_n_in; // R19
endmodule // pms_edge_det

// >>> hw/pms_conv_timer.sv
// Conversion timer: counts a fixed number of cycles after start.
// Assumes start is a one-cycle pulse; a new start restarts the count.
module pms_conv_timer
	import pms_pkg::*;
#(
	parameter int CYCLES = PMS_CONV_CYCLES
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	logic [PMS_CNT_W-1:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next, done_reg, done_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (start_in)
		begin
			cnt_next = PMS_CNT_W'(CYCLES - 1);
			busy_next = 1'b1;
		end
		else if (busy_reg)
		begin
			if (cnt_reg == '0)
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
			else
				cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign busy_out = busy_reg;
	assign done_out = done_reg;
endmodule // pms_conv_timer

// >>> hw/pms_sequencer.sv
// Power-mode sequencer: control register, power state and track-and-hold control.
// Assumes host bus writes arrive as a write strobe with data held around its rise.
module pms_sequencer
	import pms_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic convert_start_n_in,
	input wire logic wr_n_in,
	input wire logic [PMS_CTRL_W-1:0] wr_data_in,
	output logic [PMS_CTRL_W-1:0] ctrl_out,
	output logic busy_out,
	output logic conv_done_out,
	output logic analog_on_out,
	output logic ref_on_out,
	output logic track_out
);
	// ************************************************************
	// Edge detection and conversion timing
	// ************************************************************
	pms_evt_if evt ();
	logic conv_start, conv_busy, conv_done;

	pms_edge_det u_det (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.convert_start_n_in(convert_start_n_in),
		.wr_n_in(wr_n_in),
		.evt(evt)
	);

	pms_conv_timer u_timer (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.start_in(conv_start),
		.busy_out(conv_busy),
		.done_out(conv_done)
	);

	// ************************************************************
	// Control register and power state
	// ************************************************************
	logic [PMS_CTRL_W-1:0] ctrl_reg, ctrl_next;
	pms_pwr_e pwr_reg, pwr_next;
	logic track_reg, track_next;
	logic [1:0] pm, pm_wr;

	assign pm = {ctrl_reg[PMS_PM_HIGH_POS], ctrl_reg[PMS_PM_LOW_POS]};
	assign pm_wr = {wr_data_in[PMS_PM_HIGH_POS], wr_data_in[PMS_PM_LOW_POS]};
	// No conversions while fully shut down; a write in the same cycle wins, so the
	// timer never starts behind a mode change that the power state has not seen
	assign conv_start = evt.cs_fall && !evt.wr_rise && (pwr_reg == PMS_PWR_ON) &&
		!(pm == PMS_PM_FULL_SHDN); // R17 R20

	always_comb
	begin
		ctrl_next = ctrl_reg;
		pwr_next = pwr_reg;
		track_next = track_reg;
		if (evt.wr_rise)
		begin
			// Register is written only by the host; shutdown never disturbs it
			ctrl_next = wr_data_in; // R19 R4
			case (pm_wr)
				PMS_PM_FULL_SHDN:
				begin
					pwr_next = PMS_PWR_SHUTDOWN; // R12
					track_next = 1'b0;
				end
				PMS_PM_NORMAL:
				begin
					if (pwr_reg != PMS_PWR_ON)
					begin
						pwr_next = PMS_PWR_ON; // R14 R1
						track_next = 1'b1;
					end
				end
				default:
				begin
					// Leaving full shutdown into an auto mode also wakes the part
					if (pm == PMS_PM_FULL_SHDN)
					begin
						pwr_next = PMS_PWR_ON;
						track_next = 1'b1;
					end
				end
			endcase
		end
		else if (pm == PMS_PM_FULL_SHDN)
		begin
			pwr_next = PMS_PWR_SHUTDOWN; // R13 R20
			track_next = 1'b0;
		end
		else if (conv_start)
			track_next = 1'b0; // R17
		else if (conv_done)
		begin
			case (pm)
				PMS_PM_AUTO_SHDN:
				begin
					pwr_next = PMS_PWR_SHUTDOWN; // R3
					track_next = 1'b0; // R5
				end
				PMS_PM_AUTO_STBY:
				begin
					pwr_next = PMS_PWR_STANDBY; // R9
					track_next = 1'b0; // R10
				end
				default:
					track_next = 1'b1; // R1
			endcase
		end
		else if (evt.cs_rise)
		begin
			pwr_next = PMS_PWR_ON; // R6 R10
			track_next = 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			ctrl_reg <= PMS_CTRL_RESET; // R2
			pwr_reg <= PMS_PWR_ON;
			// Track-and-hold starts in hold until the first convert-start rise, the end of a normal-mode conversion or a write that wakes the part
			track_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			pwr_reg <= pwr_next;
			track_reg <= track_next;
		end
	end

	assign ctrl_out = ctrl_reg;
	assign busy_out = conv_busy; // R18
	assign conv_done_out = conv_done; // R18
	assign analog_on_out = (pwr_reg == PMS_PWR_ON);
	assign ref_on_out = (pwr_reg != PMS_PWR_SHUTDOWN);
	assign track_out = track_reg;
endmodule // pms_sequencer

// >>> verification/pms_seq_sva.sv
// Checker for the power-mode sequencer, watching its top ports only.
// Assumes one clock and a synchronous active-low reset.
module pms_seq_sva
	import pms_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic convert_start_n_in,
	input wire logic wr_n_in,
	input wire logic [PMS_CTRL_W-1:0] wr_data_in,
	input wire logic [PMS_CTRL_W-1:0] ctrl_out,
	input wire logic busy_out,
	input wire logic conv_done_out,
	input wire logic analog_on_out,
	input wire logic ref_on_out,
	input wire logic track_out
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [1:0] pm;
	assign pm = ctrl_out[1:0];
	property p_wr; $rose(wr_n_in) |=> ctrl_out == $past(wr_data_in); endproperty
	a_wr: assert property (p_wr) else $error("ctrl capture");
	property p_keep; !$rose(wr_n_in) |=> $stable(ctrl_out); endproperty
	a_keep: assert property (p_keep) else $error("ctrl changed");
	property p_full; $rose(wr_n_in) && wr_data_in[1:0] == 2'h3 |=> !analog_on_out && !ref_on_out
		&& !track_out; endproperty
	a_full: assert property (p_full) else $error("full shutdown");
	property p_wake; $rose(wr_n_in) && pm == 2'h3 && wr_data_in[1:0] == 2'h0
		|=> analog_on_out && track_out; endproperty
	a_wake: assert property (p_wake) else $error("write wake");
	property p_stay; pm == 2'h3 && !analog_on_out && !$rose(wr_n_in)
		|=> !analog_on_out && !track_out && !busy_out; endproperty
	a_stay: assert property (p_stay) else $error("left shutdown");
	property p_start; $fell(convert_start_n_in) && analog_on_out && pm != 2'h3 && !busy_out
		&& !$rose(wr_n_in) |=> busy_out && !track_out; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_done; $fell(busy_out) |-> conv_done_out; endproperty
	a_done: assert property (p_done) else $error("no done");
	property p_ashd; conv_done_out && pm == 2'h1 && !$rose(wr_n_in)
		|=> !analog_on_out && !ref_on_out && !track_out; endproperty
	a_ashd: assert property (p_ashd) else $error("autoshutdown");
	property p_stby; conv_done_out && pm == 2'h2 && !$rose(wr_n_in)
		|=> !analog_on_out && ref_on_out && !track_out; endproperty
	a_stby: assert property (p_stby) else $error("autostandby");
	property p_rise; $rose(convert_start_n_in) && (pm == 2'h1 || pm == 2'h2) && !$rose(wr_n_in)
		|=> analog_on_out && track_out; endproperty
	a_rise: assert property (p_rise) else $error("pin wake");
endmodule // pms_seq_sva

// >>> verification/pms_host.sv
// Host model driving the convert-start pin and the control-word write strobe.
// Assumes the sequencer samples these pins on the rising clock edge.
module pms_host
	import pms_pkg::*;
(
	input wire logic clk_in,
	output logic convert_start_n_out,
	output logic wr_n_out,
	output logic [PMS_CTRL_W-1:0] wr_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		convert_start_n_out = 1'b1;
		wr_n_out = 1'b1;
		wr_data_out = 12'h000;
	end
	// Data is held through the sampled strobe rise, then scrambled once released
	task automatic write(input logic [1:0] pm);
		@(posedge clk_in) #1;
		wr_data_out = {10'h000, pm};
		wr_n_out = 1'b0;
		@(posedge clk_in) #1;
		wr_n_out = 1'b1;
		@(posedge clk_in) #1;
		wr_data_out = ~wr_data_out;
	endtask
	// Convert-start idles low after a conversion until the wake rise
	task automatic cs_set(input logic lvl);
		@(posedge clk_in) #1;
		convert_start_n_out = lvl;
	endtask
	// Power-up waits after a wake, in clock cycles. The internal-reference standby
	// figure is the longer one. A 10 ms wait is far beyond the run length, so the shutdown
	// wait is cut to WAIT_CAP; the sequencer does not time power-up itself.
	localparam int WAIT_SHDN = 2000000;
	localparam int WAIT_STBY = 1400;
	localparam int WAIT_CAP = 2000;
	task automatic settle(input logic [1:0] pm);
		int cycles;
		cycles = (pm == PMS_PM_AUTO_STBY) ? WAIT_STBY : WAIT_SHDN;
		if (cycles > WAIT_CAP)
			cycles = WAIT_CAP;
		repeat (cycles) @(posedge clk_in);
	endtask
endmodule // pms_host

// >>> verification/test_adc_power_mode_sequencer.sv
// Self-checking bench for the power-mode sequencer, one row per power mode.
// Assumes a 200 MHz clock and the host model on the pin side.
module test_adc_power_mode_sequencer import pms_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic cs_n, wr_n, busy_out, conv_done_out, analog_on_out, ref_on_out, track_out;
	logic [PMS_CTRL_W-1:0] wr_data, ctrl_out;
	int n_errors = 0;
	int checks_done = 0;
	int n;
	logic [6:0] e;
	// Write, after conversion, after rise: {analog,ref},{analog,ref,track},{analog,track}
	logic [6:0] r_exp[4] = '{7'h7f, 7'h63, 7'h6b, 7'h00};
	always #2.5 clk_in = ~clk_in;
	pms_host pms_host_i (.clk_in(clk_in), .convert_start_n_out(cs_n), .wr_n_out(wr_n),
		.wr_data_out(wr_data));
	pms_sequencer pms_sequencer_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.convert_start_n_in(cs_n), .wr_n_in(wr_n), .wr_data_in(wr_data), .ctrl_out(ctrl_out),
		.busy_out(busy_out), .conv_done_out(conv_done_out), .analog_on_out(analog_on_out),
		.ref_on_out(ref_on_out), .track_out(track_out));
	task automatic chk(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t bit mismatch", $time);
		end
	endtask
	task automatic chkw(input logic [PMS_CTRL_W-1:0] got, input logic [PMS_CTRL_W-1:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t ctrl mismatch", $time);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_in);
		#1 rst_b_in = 1'b1;
		chkw(ctrl_out, 12'h000);
		chk(analog_on_out, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			e = r_exp[i];
			pms_host_i.write(i[1:0]);
			@(posedge clk_in) #1;
			chkw(ctrl_out, {10'h000, i[1:0]});
			chk(analog_on_out, e[6]);
			chk(ref_on_out, e[5]);
			pms_host_i.cs_set(1'b0);
			n = 0;
			while (n < 200 && conv_done_out !== 1'b1)
			begin
				@(posedge clk_in) #1;
				n++;
			end
			chk(n < 200, i != 3);
			chk(n == PMS_CONV_CYCLES + 1, i != 3);
			if (i != 3 && n >= 200)
				results();
			@(posedge clk_in) #1;
			chk(analog_on_out, e[4]);
			chk(ref_on_out, e[3]);
			chk(track_out, e[2]);
			chk(busy_out, 1'b0);
			chkw(ctrl_out, {10'h000, i[1:0]});
			pms_host_i.cs_set(1'b1);
			repeat (2) @(posedge clk_in);
			#1 chk(analog_on_out, e[1]);
			chk(track_out, e[0]);
			pms_host_i.write(2'h0);
			@(posedge clk_in) #1;
			chk(analog_on_out, 1'b1);
			chk(track_out, 1'b1);
			pms_host_i.settle(i[1:0]);
		end
		// An auto-mode write also leaves full shutdown
		pms_host_i.write(2'h3);
		pms_host_i.write(2'h2);
		@(posedge clk_in) #1;
		chk(analog_on_out, 1'b1);
		chk(track_out, 1'b1);
		chkw(ctrl_out, 12'h002);
		pms_host_i.write(2'h3);
		@(posedge clk_in) #1 rst_b_in = 1'b0;
		repeat (3) @(posedge clk_in);
		#1 rst_b_in = 1'b1;
		chkw(ctrl_out, 12'h000);
		chk(analog_on_out, 1'b1);
		chk(track_out, 1'b0);
		chk(busy_out, 1'b0);
		results();
	end
endmodule // test_adc_power_mode_sequencer
bind pms_sequencer pms_seq_sva pms_seq_sva_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.convert_start_n_in(convert_start_n_in), .wr_n_in(wr_n_in), .wr_data_in(wr_data_in),
	.ctrl_out(ctrl_out), .busy_out(busy_out), .conv_done_out(conv_done_out),
	.analog_on_out(analog_on_out), .ref_on_out(ref_on_out), .track_out(track_out));
